/* File: core/lifc_core.sv */
/*
  Live-insertion switch control, fault log, alert and general pin logic
  with an AXI4-Lite register slave. Assumes all pins are asynchronous
  comparator outputs and that the bus master follows AXI4-Lite.
*/
`timescale 1ns/10ps
module lifc_core
  import lifc_pkg::*;
#(
  parameter int         STARTUP_CYCLES  = STARTUP_CYC,
  parameter int         DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int         RETRY_CYCLES    = RETRY_CYC,
  parameter int         BREAKER_CYCLES  = BREAKER_CYC,
  parameter logic [6:0] ADDR_BASE       = 7'h40
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire lifc_pins_s    pins,
  input  wire lifc_axi_req_s axi_req,
  output lifc_axi_rsp_s      axi_rsp,
  output lifc_drv_s          drv
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    lifc_pins_s         sync1;
    lifc_pins_s         sync2;
    lifc_pins_s         prev;
    logic [1:0]         prime;
    lifc_state_e        st;
    logic [CNT_W-1:0]   cnt;
    logic [BRK_W-1:0]   brk;
    logic [CTRL_W-1:0]  ctrl;
    logic [FAULT_W-1:0] alert_en;
    logic [FAULT_W-1:0] fault;
    logic               fast;
    logic               alert;
    logic               gpio_oe;
    logic [6:0]         bus_addr;
    logic [7:0]         awaddr;
    logic               aw_got;
    logic               w_got;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } lifc_core_s;

  lifc_core_s         s;
  lifc_core_s         n;
  lifc_pins_s         p;
  logic               edges_ok;
  logic               on_rise;
  logic               on_fall;
  logic               card_in;
  logic               card_chg;
  logic               valid;
  logic               gate;
  logic               latched;
  logic               start_done;
  logic               cool_end;
  logic               brk_trip;
  logic [FAULT_W-1:0] fault_set;
  logic [FAULT_W-1:0] fault_clr;
  logic [31:0]        status;

  // --------------------------------------------------------------
  // Decoders
  // --------------------------------------------------------------
  // Tri-state pin code {high, low}: low 0, high 1, open 2
  function automatic logic [4:0] trit(input logic [1:0] c);
    if (c[0]) begin
      trit = 5'h00;
    end else if (c[1]) begin
      trit = 5'h01;
    end else begin
      trit = 5'h02;
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_ALERT) ||
             (a == OFS_FAULT) || (a == OFS_STATUS);
  endfunction

  // --------------------------------------------------------------
  // Conditions from synchronised pins
  // --------------------------------------------------------------
  // Edges only after the pipeline is primed, so reset zeros fake none
  assign p          = s.sync2;
  assign edges_ok   = (s.prime == 2'h3);
  assign on_rise    = edges_ok && p.on_req && !s.prev.on_req;
  assign on_fall    = edges_ok && !p.on_req && s.prev.on_req;
  assign card_in    = edges_ok && !p.card_absent && s.prev.card_absent;
  assign card_chg   = edges_ok && (p.card_absent != s.prev.card_absent);
  assign valid      = p.uv_ok && !p.ov_trip && !p.card_absent && !p.uvlo_trip;
  assign gate       = (s.st == ST_STARTUP) || (s.st == ST_ON);
  assign latched    = s.fault[F_OC] && !s.ctrl[C_RETRY];
  assign start_done = p.timer_internal ? (s.cnt >= CNT_W'(STARTUP_CYCLES - 1))
                                       : p.timer_done;
  assign cool_end   = p.timer_internal ? (s.cnt >= CNT_W'(RETRY_CYCLES - 1))
                                       : p.cool_done;
  assign brk_trip   = p.breaker_over && (s.brk >= BRK_W'(BREAKER_CYCLES - 1));
  assign status     = {17'h00000, s.bus_addr, s.fast, gate && (s.st == ST_STARTUP),
                       p.gpio_in, p.ov_trip, p.uv_ok, !p.card_absent,
                       p.power_good, gate};

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  // One pass builds every next value; later sections take priority
  always_comb begin
    n         = s;
    fault_set = '0;
    fault_clr = '0;

    // Two-stage synchronisers and edge history
    n.sync1 = pins;
    n.sync2 = s.sync1;
    n.prev  = s.sync2;
    if (!edges_ok) begin
      n.prime = s.prime + 2'h1;
    end
    n.bus_addr = ADDR_BASE + 7'(trit(p.bus_addr_sel0) + 5'(3 * trit(p.bus_addr_sel1))
               + 5'(9 * trit(p.bus_addr_sel2)));

    // Register writes once address and data are both held
    if (axi_req.awvalid && axi_rsp.awready) begin
      n.awaddr = axi_req.awaddr;
      n.aw_got = 1'b1;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      n.wdata = axi_req.wdata;
      n.wstrb = axi_req.wstrb;
      n.w_got = 1'b1;
    end
    if (s.aw_got && s.w_got) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = mapped(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s.wstrb[0]) begin
        unique case (s.awaddr)
          OFS_CTRL:  n.ctrl = s.wdata[CTRL_W-1:0];
          OFS_ALERT: n.alert_en = s.wdata[FAULT_W-1:0];
          OFS_FAULT: fault_clr = s.wdata[FAULT_W-1:0];
          default:   n.ctrl = s.ctrl;
        endcase
      end
    end else if (s.bvalid && axi_req.bready) begin
      n.bvalid = 1'b0;
    end

    // Register reads
    if (axi_req.arvalid && axi_rsp.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (axi_req.araddr)
        OFS_CTRL:   n.rdata = {27'h0000000, s.ctrl};
        OFS_ALERT:  n.rdata = {27'h0000000, s.alert_en};
        OFS_FAULT:  n.rdata = {27'h0000000, s.fault};
        OFS_STATUS: n.rdata = status;
        default:    n.rdata = 32'h00000000;
      endcase
    end else if (s.rvalid && axi_req.rready) begin
      n.rvalid = 1'b0;
    end

    // Switch sequence
    unique case (s.st)
      ST_WAIT: begin
        if (!valid) begin
          n.cnt = '0;
        end else if (s.cnt >= CNT_W'(DEBOUNCE_CYCLES - 1)) begin
          n.cnt             = '0;
          n.st              = ST_OFF;
          n.ctrl[C_SWITCH_ON] = p.on_req;
        end else begin
          n.cnt = s.cnt + 1'b1;
        end
      end
      ST_OFF: begin
        n.cnt = '0;
        if (!valid) begin
          n.st = ST_WAIT;
        end else if (s.ctrl[C_SWITCH_ON] && !latched) begin
          n.st   = ST_STARTUP;
          n.fast = 1'b0;
        end
      end
      ST_STARTUP: begin
        n.cnt = s.cnt + 1'b1;
        if (!valid) begin
          n.st = ST_WAIT;
        end else if (!s.ctrl[C_SWITCH_ON]) begin
          n.st = ST_OFF;
        end else if (start_done) begin
          n.cnt = '0;
          if (p.cur_limit) begin
            fault_set[F_OC] = 1'b1;
            n.fast = 1'b1;
            n.st   = s.ctrl[C_RETRY] ? ST_COOL : ST_OFF;
          end else begin
            n.st = ST_ON;
          end
        end
      end
      ST_ON: begin
        if (!valid) begin
          n.st = ST_WAIT;
        end else if (!s.ctrl[C_SWITCH_ON]) begin
          n.st = ST_OFF;
        end else if (brk_trip) begin
          fault_set[F_OC] = 1'b1;
          n.fast = 1'b1;
          n.st   = s.ctrl[C_RETRY] ? ST_COOL : ST_OFF;
        end
      end
      ST_COOL: begin
        n.cnt = s.cnt + 1'b1;
        if (!valid) begin
          n.st  = ST_WAIT;
          n.cnt = '0;
        end else if (cool_end) begin
          n.st  = ST_OFF;
          n.cnt = '0;
        end
      end
      default: begin
        n.st  = ST_WAIT;
        n.cnt = '0;
      end
    endcase

    // Breaker filter counts only while armed and over threshold
    if ((s.st == ST_ON) && p.breaker_over && !brk_trip) begin
      n.brk = s.brk + 1'b1;
    end else begin
      n.brk = '0;
    end

    // Supply lockout discharges the gate hard
    if (gate && p.uvlo_trip) begin
      n.fast = 1'b1;
    end

    // Request and card edges override software on the switch bit
    if (on_rise && (s.st != ST_WAIT)) begin
      n.ctrl[C_SWITCH_ON] = 1'b1;
    end
    if (on_fall) begin
      n.ctrl[C_SWITCH_ON] = 1'b0;
      fault_clr = '1;
    end
    if (card_in) begin
      n.ctrl[C_SWITCH_ON] = p.on_req;
      fault_clr = '1;
    end
    if (p.uv_reset) begin
      fault_clr = '1;
    end

    // Fault logging; a new event wins over a clear
    if (p.ov_trip) begin
      fault_set[F_OV] = 1'b1;
    end
    if (!p.uv_ok) begin
      fault_set[F_UV] = 1'b1;
    end
    if ((s.st == ST_ON) && !p.power_good) begin
      fault_set[F_PBAD] = 1'b1;
    end
    if (card_chg) begin
      fault_set[F_CARD] = 1'b1;
    end
    // Reset zeros still in the synchroniser are not pin levels, so they log nothing
    n.fault = (s.fault & ~fault_clr) | (s.prime[1] ? fault_set : '0);

    // Alert and general pin drive
    n.alert = |(s.fault & s.alert_en);
    unique case ({s.ctrl[C_CFG_HI], s.ctrl[C_CFG_LO]})
      2'h0:    n.gpio_oe = !p.power_good;
      2'h1:    n.gpio_oe = p.power_good;
      2'h2:    n.gpio_oe = s.ctrl[C_GPIO_LOW];
      default: n.gpio_oe = 1'b0;
    endcase
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  // Reset restores fault log and control defaults
  always_ff @(posedge mclk) begin
    if (rst) begin
      s          <= '0;
      s.st       <= ST_WAIT;
      s.ctrl     <= CTRL_RST;
      s.alert_en <= ALERT_RST;
    end else begin
      s <= n;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  // Open-drain pins only ever pull low
  assign drv = '{gate_on:            gate,
                 gate_fast_pulldown: s.fast && !gate,
                 foldback_active:    s.st == ST_STARTUP,
                 alert_oe:           s.alert,
                 alert_out:          1'b0,
                 gpio_oe:            s.gpio_oe,
                 gpio_out:           1'b0};

  assign axi_rsp = '{awready: !s.aw_got && !s.bvalid,
                     wready:  !s.w_got && !s.bvalid,
                     bvalid:  s.bvalid,
                     bresp:   s.bresp,
                     arready: !s.rvalid,
                     rvalid:  s.rvalid,
                     rdata:   s.rdata,
                     rresp:   s.rresp};

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_start_short;
    (s.st == ST_STARTUP) && valid && s.ctrl[C_SWITCH_ON] && start_done && p.cur_limit;
  endsequence

  sequence s_trip;
    (s.st == ST_ON) && valid && s.ctrl[C_SWITCH_ON] && brk_trip;
  endsequence

  a_rise_sets_on: assert property (on_rise && s.st != ST_WAIT |=> s.ctrl[C_SWITCH_ON])
    else $error("switch bit not set by request rise");
  a_fall_clears: assert property (on_fall |=> !s.ctrl[C_SWITCH_ON] ##1 !gate)
    else $error("request fall did not stop switch");
  a_card_inhibit: assert property (p.card_absent |=> !gate)
    else $error("gate on with card absent");
  a_card_event: assert property (card_chg |=> s.fault[F_CARD])
    else $error("card change not logged");
  a_alert_map: assert property (##1 drv.alert_oe == $past(|(s.fault & s.alert_en)))
    else $error("alert does not follow enabled faults");
  a_pbad_log: assert property ((s.st == ST_ON) && !p.power_good |=> s.fault[F_PBAD])
    else $error("power bad not logged");
  a_pbad_gate: assert property ($rose(s.fault[F_PBAD]) |-> $past(gate))
    else $error("power bad logged with gate off");
  a_fold_start: assert property ($rose(gate) |-> drv.foldback_active)
    else $error("start-up without foldback");
  a_gpio_default: assert property (s.ctrl[2:1] == 2'h0 |=> drv.gpio_oe == $past(!p.power_good))
    else $error("general pin default wrong");
  a_ov_off: assert property (s.prime[1] && p.ov_trip |=> !gate && s.fault[F_OV])
    else $error("overvoltage not handled");
  a_uv_off: assert property (s.prime[1] && !p.uv_ok |=> !gate && s.fault[F_UV])
    else $error("undervoltage not handled");
  a_uv_reset: assert property (p.uv_reset |=> !s.fault[F_OC] && !s.fault[F_PBAD])
    else $error("faults not reset");
  a_start_short: assert property (s_start_short |=> s.fault[F_OC] && !gate && s.fast)
    else $error("start-up short not caught");
  a_breaker_trip: assert property (s_trip |=> s.fault[F_OC] && !gate ##1 drv.gate_fast_pulldown)
    else $error("breaker trip not handled");
  a_debounce_hold: assert property ($rose(s.st == ST_OFF) |-> $past(valid, 2))
    else $error("turn-on allowed without settled inputs");

endmodule

/* File: include/lifc_pkg.sv */
/*
  Constants, carriers and types of the live-insertion fault control block.
  Assumes a single 10 MHz clock and analog comparators outside the block.
*/
package lifc_pkg;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_HZ        = 10_000_000;
  localparam int T_STARTUP_MS  = 100;
  localparam int T_DEBOUNCE_MS = 100;
  localparam int T_RETRY_S     = 5;
  localparam int T_BREAKER_US  = 20;
  localparam int STARTUP_CYC   = T_STARTUP_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_CYC  = T_DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int RETRY_CYC     = T_RETRY_S * CLK_HZ;
  localparam int BREAKER_CYC   = T_BREAKER_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W         = 26;
  localparam int BRK_W         = 16;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ALERT  = 8'h04;
  localparam logic [7:0] OFS_FAULT  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam int CTRL_W      = 5;
  localparam int C_SWITCH_ON = 0;
  localparam int C_CFG_LO    = 1;
  localparam int C_CFG_HI    = 2;
  localparam int C_RETRY     = 3;
  localparam int C_GPIO_LOW  = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam int FAULT_W = 5;
  localparam int F_OV    = 0;
  localparam int F_UV    = 1;
  localparam int F_OC    = 2;
  localparam int F_PBAD  = 3;
  localparam int F_CARD  = 4;
  localparam logic [FAULT_W-1:0] ALERT_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [2:0] {ST_WAIT, ST_OFF, ST_STARTUP, ST_ON, ST_COOL} lifc_state_e;

  typedef struct packed {
    logic       on_req;
    logic       card_absent;
    logic       uv_ok;
    logic       uv_reset;
    logic       ov_trip;
    logic       power_good;
    logic       cur_limit;
    logic       breaker_over;
    logic       timer_done;
    logic       cool_done;
    logic       uvlo_trip;
    logic       gpio_in;
    logic       timer_internal;
    logic [1:0] bus_addr_sel0;
    logic [1:0] bus_addr_sel1;
    logic [1:0] bus_addr_sel2;
  } lifc_pins_s;

  typedef struct packed {
    logic gate_on;
    logic gate_fast_pulldown;
    logic foldback_active;
    logic alert_oe;
    logic alert_out;
    logic gpio_oe;
    logic gpio_out;
  } lifc_drv_s;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } lifc_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } lifc_axi_rsp_s;

endpackage

/* File: verification/lifc_host_model.sv */
/*
  AXI4-Lite host model for the register slave of the fault control block.
  Assumes one clock and a slave that answers before the bench watchdog.
*/
`timescale 1ns/10ps
module lifc_host_model
  import lifc_pkg::*;
(
  input  wire logic          mclk,
  input  wire lifc_axi_rsp_s axi_rsp,
  output lifc_axi_req_s      axi_req
);
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  // Bus idle from time zero
  initial axi_req = '0;

  // Write one word; address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hit;
    logic w_hit;
    logic done;
    @(posedge mclk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= a;
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hF;
    axi_req.bready  <= 1'b1;
    done = 1'b0;
    while (!done) begin
      // Sample settled handshakes, act on the next rising edge
      @(negedge mclk);
      aw_hit = axi_req.awvalid && axi_rsp.awready;
      w_hit  = axi_req.wvalid && axi_rsp.wready;
      done   = axi_rsp.bvalid;
      r      = axi_rsp.bresp;
      @(posedge mclk);
      if (aw_hit) axi_req.awvalid <= 1'b0;
      if (w_hit) axi_req.wvalid <= 1'b0;
      if (done) axi_req.bready <= 1'b0;
    end
  endtask

  // Read one word
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hit;
    logic done;
    @(posedge mclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= a;
    axi_req.rready  <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge mclk);
      ar_hit = axi_req.arvalid && axi_rsp.arready;
      done   = axi_rsp.rvalid;
      d      = axi_rsp.rdata;
      r      = axi_rsp.rresp;
      @(posedge mclk);
      if (ar_hit) axi_req.arvalid <= 1'b0;
      if (done) axi_req.rready <= 1'b0;
    end
  endtask
endmodule

/* File: verification/tb_top.sv */
/*
  Self-checking bench of the live-insertion fault control block.
  Assumes shortened timer parameters and the host model for bus access.
*/
`timescale 1ns/10ps
module tb_top
  import lifc_pkg::*;
;
  logic          mclk;
  logic          rst;
  lifc_pins_s    pins;
  lifc_axi_req_s axi_req;
  lifc_axi_rsp_s axi_rsp;
  lifc_drv_s     drv;
  int            failures;
  int            samples_checked;
  logic [31:0]   rd_d;
  logic [1:0]    rd_r;

  // ------------------------------------------------------------
  // Design and host
  // ------------------------------------------------------------
  // Short timers keep the run brief
  lifc_core #(.STARTUP_CYCLES(50), .DEBOUNCE_CYCLES(40), .RETRY_CYCLES(200),
              .BREAKER_CYCLES(5)) i_lifc_core (
    .mclk    (mclk),
    .rst     (rst),
    .pins    (pins),
    .axi_req (axi_req),
    .axi_rsp (axi_rsp),
    .drv     (drv)
  );
  lifc_host_model i_lifc_host_model (
    .mclk    (mclk),
    .axi_rsp (axi_rsp),
    .axi_req (axi_req)
  );

  // Clock source
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Read a register and compare its data
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    i_lifc_host_model.rd(a, rd_d, rd_r);
    chk(rd_d, exp);
  endtask

  task automatic wrreg(input logic [7:0] a, input logic [31:0] d);
    i_lifc_host_model.wr(a, d, rd_r);
  endtask

  // Wait a bounded time for the gate drive level, then compare it
  task automatic wgate(input logic v);
    int n;
    n = 0;
    @(negedge mclk);
    while (drv.gate_on !== v && n < 300) begin
      @(negedge mclk);
      n++;
    end
    chk({31'h0, drv.gate_on}, {31'h0, v});
    @(posedge mclk);
  endtask

  // Look at one settled drive bit: 6 gate_on, 5 fast pulldown, 1 gpio_oe
  task automatic pchk(input int b, input logic exp);
    @(negedge mclk);
    chk({31'h0, drv[b]}, {31'h0, exp});
  endtask

  // Report and end the run
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #2_000_000;
    failures++;
    close_out();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    failures        = 0;
    samples_checked = 0;
    rst             = 1'b1;
    pins            = '0;
    pins.on_req     = 1'b1;
    pins.uv_ok      = 1'b1;
    pins.timer_internal = 1'b1;
    pins.bus_addr_sel0  = 2'b10;
    pins.bus_addr_sel2  = 2'b01;
    cyc(5);
    rst <= 1'b0;
    // Reset defaults, address decode, unmapped place
    cyc(5);
    @(negedge mclk);
    chk({31'h0, drv.gpio_oe}, 32'h1);
    rdchk(OFS_CTRL, 32'h0);
    rdchk(OFS_FAULT, 32'h0);
    i_lifc_host_model.rd(OFS_STATUS, rd_d, rd_r);
    chk({25'h0, rd_d[14:8]}, 32'h47);
    rdchk(8'h10, 32'h0);
    chk({30'h0, rd_r}, {30'h0, RESP_SLVERR});
    wrreg(8'h10, 32'h0);
    chk({30'h0, rd_r}, {30'h0, RESP_SLVERR});
    $display("test reset done");
    // Start-up after debounce with request high
    @(negedge mclk);
    chk({31'h0, drv.gate_on}, 32'h0);
    wgate(1'b1);
    rdchk(OFS_CTRL, 32'h1);
    @(negedge mclk);
    chk({31'h0, drv.foldback_active}, 32'h1);
    cyc(60);
    @(negedge mclk);
    chk({30'h0, drv.gate_on, drv.foldback_active}, 32'h2);
    @(posedge mclk);
    pins.power_good <= 1'b1;
    cyc(6);
    @(negedge mclk);
    chk({31'h0, drv.gpio_oe}, 32'h0);
    @(posedge mclk);
    pins.power_good <= 1'b0;
    cyc(6);
    @(negedge mclk);
    chk({31'h0, drv.gpio_oe}, 32'h1);
    rdchk(OFS_FAULT, 32'h8);
    pins.power_good <= 1'b1;
    wrreg(OFS_CTRL, 32'h3);
    chk({30'h0, rd_r}, {30'h0, RESP_OKAY});
    cyc(6);
    @(negedge mclk);
    chk({31'h0, drv.gpio_oe}, 32'h1);
    wrreg(OFS_CTRL, 32'h7);
    pchk(1, 1'b0);
    wrreg(OFS_CTRL, 32'h15);
    pchk(1, 1'b1);
    wrreg(OFS_CTRL, 32'h1);
    wrreg(OFS_FAULT, 32'h1F);
    rdchk(OFS_FAULT, 32'h0);
    $display("test startup done");
    // Overvoltage trip with alert enabled
    wrreg(OFS_ALERT, 32'h1);
    pins.ov_trip <= 1'b1;
    wgate(1'b0);
    pins.ov_trip <= 1'b0;
    rdchk(OFS_FAULT, 32'h1);
    @(negedge mclk);
    chk({31'h0, drv.alert_oe}, 32'h1);
    wgate(1'b1);
    $display("test overvoltage done");
    // Request edges and host turn-on
    @(posedge mclk);
    pins.on_req <= 1'b0;
    wgate(1'b0);
    rdchk(OFS_FAULT, 32'h0);
    @(negedge mclk);
    chk({31'h0, drv.alert_oe}, 32'h0);
    wrreg(OFS_CTRL, 32'h1);
    wgate(1'b1);
    wrreg(OFS_CTRL, 32'h0);
    wgate(1'b0);
    pins.on_req <= 1'b1;
    wgate(1'b1);
    $display("test request done");
    // Card removal and insertion
    pins.card_absent <= 1'b1;
    wgate(1'b0);
    rdchk(OFS_FAULT, 32'h10);
    pins.ov_trip <= 1'b1;
    cyc(4);
    pins.ov_trip <= 1'b0;
    cyc(4);
    rdchk(OFS_FAULT, 32'h11);
    pins.card_absent <= 1'b0;
    wgate(1'b1);
    rdchk(OFS_FAULT, 32'h10);
    $display("test card done");
    // Start-up into a short
    wrreg(OFS_FAULT, 32'h1F);
    pins.on_req    <= 1'b0;
    pins.cur_limit <= 1'b1;
    wgate(1'b0);
    pins.on_req <= 1'b1;
    wgate(1'b1);
    wgate(1'b0);
    @(negedge mclk);
    chk({31'h0, drv.gate_fast_pulldown}, 32'h1);
    rdchk(OFS_FAULT, 32'h4);
    $display("test short done");
    // Breaker trip with auto-retry and cool-down
    pins.cur_limit <= 1'b0;
    wrreg(OFS_CTRL, 32'h9);
    wrreg(OFS_FAULT, 32'h1F);
    wgate(1'b1);
    cyc(60);
    pins.breaker_over <= 1'b1;
    wgate(1'b0);
    pins.breaker_over <= 1'b0;
    rdchk(OFS_FAULT, 32'h4);
    cyc(100);
    pchk(6, 1'b0);
    wgate(1'b1);
    $display("test breaker done");
    // Undervoltage fault and reset level
    pins.uv_ok     <= 1'b0;
    cyc(6);
    rdchk(OFS_FAULT, 32'h6);
    pins.uv_reset <= 1'b1;
    cyc(6);
    i_lifc_host_model.rd(OFS_FAULT, rd_d, rd_r);
    chk(rd_d & 32'h4, 32'h0);
    $display("test undervoltage done");
    close_out();
  end
endmodule
